// File: adc_converter_model.sv
// Behavioural model of the serial sampling converter on the far side of the sequencer.
`timescale 1ns/1ps

module adc_converter_model (
    input  wire logic        sample_cmd_i, // Sample command, high = acquire.
    input  wire logic        conv_clk_i,   // Conversion clock from the host.
    input  wire logic [15:0] word_i,       // Base of the words to send.
    input  wire logic        mute_i,       // Withhold busy to starve the host.
    output logic             busy_o,       // Frame announce, active high.
    output logic             data_o,       // Serial data, changes on clock rise.
    output logic      [15:0] sent_o,       // Words sent so far.
    output logic      [15:0] viol_o        // Host timing violations seen.
);
    int          bit_idx = -1;
    logic [15:0] shreg   = 16'h0000;

    initial begin
        busy_o = 1'b0;
        data_o = 1'b0;
        sent_o = 16'h0000;
        viol_o = 16'h0000;
    end

    // Each word is the base plus the count sent so far, so consecutive words differ.
    always @(negedge sample_cmd_i) begin
        if (conv_clk_i !== 1'b0) begin
            viol_o = viol_o + 16'h0001;
        end
        shreg   = word_i + sent_o;
        bit_idx = 0;
    end

    always @(posedge sample_cmd_i) begin
        bit_idx = -1;
        busy_o  = 1'b0;
        data_o  = ~data_o;
    end

    always @(posedge conv_clk_i) begin
        if (sample_cmd_i) begin
            viol_o = viol_o + 16'h0001;
        end else if (bit_idx == 0 && !mute_i) begin
            busy_o  = 1'b1;
            bit_idx = 1;
        end else if (bit_idx >= 1 && bit_idx <= 16) begin
            busy_o  = 1'b0;
            data_o  = shreg[16-bit_idx];
            bit_idx = bit_idx + 1;
            sent_o  = (bit_idx == 17) ? sent_o + 16'h0001 : sent_o;
        end else begin
            // The released line toggles so that no stale level can pass for data.
            data_o = ~data_o;
        end
    end
endmodule : adc_converter_model

// File: adc_sample_readout_sequencer.sv
// Host sequencer that samples, clocks and reads out a serial sampling converter.
//
// How it works
// - Conversion clock runs near 2 MHz.
// - Clock stopped while the converter acquires.
// - Clock held low when sample command falls.
// - Clock restarts right after sample command falls.
// - Busy is a non-inverted, normal-framing frame sync.
// - Completion pulse after the last bit.
// - Sample command rises right after last bit.
// - Sample commands no faster than 100 kHz.
// - Filter mode runs converter at 96 kHz.
// - Filter mode: same pins carry hold and clock.
// - Filter mode keeps every second word.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"

module adc_sample_readout_sequencer #(
    parameter int WORD_BITS     = `WORD_BITS,
    parameter int FIFO_DEPTH    = `FIFO_DEPTH,
    parameter int PERIOD_CYC    = `MIN_PERIOD_CYC,
    parameter int FILTER_PERIOD = `FILTER_PERIOD_CYC,
    parameter int ACQ_CYC       = `ACQ_CYC,
    parameter int TIMEOUT_CLKS  = `CONV_TIMEOUT_CLKS
) (
    input  wire logic                 clk_sys_i,                  // System clock, 250 MHz.
    input  wire logic                 rst_i,                      // Synchronous reset.
    input  wire logic                 enable_i,                   // Run conversions.
    input  wire logic                 filter_mode_i,              // 96 kHz filter arrangement.
    output logic                      host_flag_output_o,         // Sample command to converter.
    output logic                      filter_bit_clock_output_o,  // Conversion clock out.
    input  wire logic                 host_receive_frame_input_i, // Busy from converter.
    input  wire logic                 serial_data_i,              // Serial data from converter.
    output logic                      word_done_o,                // Pulse: word received.
    output logic                      frame_error_o,              // Pulse: no word in time.
    output logic                      sample_valid_o,             // Sample word available.
    input  wire logic                 sample_ready_i,             // Consumer takes word.
    output logic      [WORD_BITS-1:0] sample_data_o               // Two's complement sample.
);
    import adc_seq_pkg::*;

    localparam int HALF = `SCLK_HALF_CYC;
    localparam int MINP = `MIN_PERIOD_CYC;
    localparam int FILP = `FILTER_PERIOD_CYC;
    localparam int BCW  = $clog2(WORD_BITS + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic busy_meta;
    logic busy_s;
    logic data_meta;
    logic data_s;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_meta <= 1'b0;
            busy_s    <= 1'b0;
            data_meta <= 1'b0;
            data_s    <= 1'b0;
        end else begin
            busy_meta <= host_receive_frame_input_i;
            busy_s    <= busy_meta;
            data_meta <= serial_data_i;
            data_s    <= data_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    seq_state_t           state;
    seq_state_t           next_state;
    logic [7:0]           div_cnt;
    logic [7:0]           next_div_cnt;
    logic                 next_sclk;
    logic                 next_flag;
    logic [15:0]          per_cnt;
    logic [15:0]          next_per_cnt;
    logic [15:0]          acq_cnt;
    logic [15:0]          next_acq_cnt;
    logic                 framed;
    logic                 next_framed;
    logic [BCW-1:0]       bit_cnt;
    logic [BCW-1:0]       next_bit_cnt;
    logic [7:0]           fall_cnt;
    logic [7:0]           next_fall_cnt;
    logic [WORD_BITS-1:0] shift;
    logic [WORD_BITS-1:0] next_shift;
    logic                 decim_phase;
    logic                 next_decim_phase;
    logic                 push_valid;
    logic                 next_push_valid;
    logic [WORD_BITS-1:0] push_data;
    logic [WORD_BITS-1:0] next_push_data;
    logic                 next_word_done;
    logic                 next_frame_error;
    logic                 fifo_in_ready;
    logic                 fall_ev;
    logic                 rise_ev;
    logic                 start_ok;

    assign fall_ev  = (state == ST_CONVERT) && filter_bit_clock_output_o
                      && (div_cnt == 8'(HALF - 1));
    assign rise_ev  = (state == ST_CONVERT) && !filter_bit_clock_output_o
                      && (div_cnt == 8'(HALF - 1));
    // A new conversion starts only with room for its word, so no sample is dropped.
    assign start_ok = enable_i && fifo_in_ready && (acq_cnt >= 16'(ACQ_CYC))
                      && (per_cnt == '0) && !filter_bit_clock_output_o;

    always_comb begin
        next_state       = state;
        next_div_cnt     = div_cnt;
        next_sclk        = filter_bit_clock_output_o;
        next_flag        = host_flag_output_o;
        next_per_cnt     = (per_cnt != '0) ? per_cnt - 16'h0001 : per_cnt;
        next_acq_cnt     = (acq_cnt != 16'hFFFF) ? acq_cnt + 16'h0001 : acq_cnt;
        next_framed      = framed;
        next_bit_cnt     = bit_cnt;
        next_fall_cnt    = fall_cnt;
        next_shift       = shift;
        next_decim_phase = decim_phase;
        next_push_valid  = 1'b0;
        next_push_data   = push_data;
        next_word_done   = 1'b0;
        next_frame_error = 1'b0;
        unique case (state)
            ST_IDLE: begin
                next_flag = 1'b1;
                next_sclk = 1'b0;
                if (enable_i) begin
                    next_state   = ST_ACQUIRE;
                    next_acq_cnt = '0;
                end
            end
            ST_ACQUIRE: begin
                next_sclk = 1'b0;
                if (!enable_i) begin
                    next_state = ST_IDLE;
                end else if (start_ok) begin
                    next_state   = ST_CONVERT;
                    next_flag    = 1'b0;
                    next_div_cnt = '0;
                    next_framed  = 1'b0;
                    next_bit_cnt = '0;
                    next_fall_cnt = '0;
                    // Spacing follows the mode, never under the fastest legal rate.
                    next_per_cnt = filter_mode_i ? 16'(FILTER_PERIOD - 1)
                                                 : 16'(PERIOD_CYC - 1);
                end
            end
            ST_CONVERT: begin
                next_div_cnt = (div_cnt == 8'(HALF - 1)) ? '0 : div_cnt + 8'h01;
                if (rise_ev) begin
                    next_sclk = 1'b1;
                end
                if (fall_ev) begin
                    next_sclk     = 1'b0;
                    next_fall_cnt = fall_cnt + 8'h01;
                    if (!framed) begin
                        next_framed = busy_s;
                    end else begin
                        next_shift   = {shift[WORD_BITS-2:0], data_s};
                        next_bit_cnt = bit_cnt + BCW'(1);
                        if (bit_cnt == BCW'(WORD_BITS - 1)) begin
                            next_state       = ST_ACQUIRE;
                            next_flag        = 1'b1;
                            next_acq_cnt     = '0;
                            next_word_done   = 1'b1;
                            next_push_data   = {shift[WORD_BITS-2:0], data_s};
                            next_decim_phase = filter_mode_i ? !decim_phase : 1'b0;
                            next_push_valid  = !filter_mode_i || !decim_phase;
                        end
                    end
                    if (!(framed && bit_cnt == BCW'(WORD_BITS - 1))
                        && fall_cnt == 8'(TIMEOUT_CLKS - 1)) begin
                        next_state       = ST_ACQUIRE;
                        next_flag        = 1'b1;
                        next_acq_cnt     = '0;
                        next_frame_error = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state                     <= ST_IDLE;
            div_cnt                   <= '0;
            filter_bit_clock_output_o <= 1'b0;
            host_flag_output_o        <= 1'b1;
            per_cnt                   <= '0;
            acq_cnt                   <= '0;
            framed                    <= 1'b0;
            bit_cnt                   <= '0;
            fall_cnt                  <= '0;
            shift                     <= '0;
            decim_phase               <= 1'b0;
            push_valid                <= 1'b0;
            push_data                 <= '0;
            word_done_o               <= 1'b0;
            frame_error_o             <= 1'b0;
        end else begin
            state                     <= next_state;
            div_cnt                   <= next_div_cnt;
            filter_bit_clock_output_o <= next_sclk;
            host_flag_output_o        <= next_flag;
            per_cnt                   <= next_per_cnt;
            acq_cnt                   <= next_acq_cnt;
            framed                    <= next_framed;
            bit_cnt                   <= next_bit_cnt;
            fall_cnt                  <= next_fall_cnt;
            shift                     <= next_shift;
            decim_phase               <= next_decim_phase;
            push_valid                <= next_push_valid;
            push_data                 <= next_push_data;
            word_done_o               <= next_word_done;
            frame_error_o             <= next_frame_error;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample buffer.

    sample_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_data),
        .out_valid_o (sample_valid_o),
        .out_ready_i (sample_ready_i),
        .out_data_o  (sample_data_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [7:0]  hi_run;
    logic [15:0] gap;
    logic        seen_fall;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hi_run    <= '0;
            gap       <= '0;
            seen_fall <= 1'b0;
        end else begin
            hi_run    <= filter_bit_clock_output_o ? hi_run + 8'h01 : '0;
            gap       <= $fell(host_flag_output_o) ? 16'h0001
                         : ((gap != 16'hFFFF) ? gap + 16'h0001 : gap);
            seen_fall <= seen_fall || $fell(host_flag_output_o);
        end
    end

    AST_CLK_HALF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(filter_bit_clock_output_o) |-> hi_run == 8'(HALF))
        else $error("Conversion clock high phase has the wrong length.");

    AST_CLK_STOPPED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        host_flag_output_o |-> !filter_bit_clock_output_o)
        else $error("Conversion clock toggles during acquisition.");

    AST_CLK_LOW_AT_FALL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(host_flag_output_o) |-> !filter_bit_clock_output_o
            && !$past(filter_bit_clock_output_o))
        else $error("Conversion clock not low when sample command falls.");

    AST_CLK_RESTART: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(host_flag_output_o) |-> ##63 filter_bit_clock_output_o)
        else $error("Conversion clock did not restart after sample command fell.");

    AST_FRAME_SYNC: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(framed) |-> $past(busy_s) && $past(fall_ev))
        else $error("Frame taken without busy high at a clock fall.");

    AST_DONE_PULSE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        word_done_o |-> $past(fall_ev) && $past(bit_cnt) == BCW'(WORD_BITS - 1)
            ##1 !word_done_o)
        else $error("Completion pulse not tied to the last bit.");

    AST_SAMPLE_RISE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        word_done_o |-> $rose(host_flag_output_o))
        else $error("Sample command did not rise after the last bit.");

    AST_MAX_RATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(host_flag_output_o) && seen_fall |-> gap >= 16'(MINP))
        else $error("Sample commands faster than the maximum rate.");

    AST_FILTER_RATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(host_flag_output_o) && seen_fall && filter_mode_i
            && $past(filter_mode_i, 2) |-> gap >= 16'(FILP))
        else $error("Filter mode sample spacing too short.");

    AST_DECIMATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        word_done_o && filter_mode_i |-> push_valid == !$past(decim_phase))
        else $error("Filter mode did not keep alternate words.");

    AST_WORD_MSB_FIRST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        push_valid |-> push_data == {$past(shift[WORD_BITS-2:0]), $past(data_s)})
        else $error("Pushed word not assembled MSB first.");

endmodule : adc_sample_readout_sequencer

// File: adc_sample_readout_sequencer_test.sv
// Self-checking testbench of the converter readout sequencer against a converter model.
`timescale 1ns/1ps

module adc_sample_readout_sequencer_test;
    localparam int S_CMD   = 0;
    localparam int S_CLK   = 1;
    localparam int S_DONE  = 2;
    localparam int S_ERR   = 3;
    localparam int S_VALID = 4;

    logic        clk_sys_i      = 1'b0;
    logic        rst_i          = 1'b1;
    logic        enable_i       = 1'b0;
    logic        filter_mode_i  = 1'b0;
    logic        sample_ready_i = 1'b0;
    logic        mute           = 1'b0;
    logic [15:0] word           = 16'hA5C3;
    logic        cmd, conv_clk, busy, sdata, word_done, frame_error, sample_valid;
    logic [15:0] sample_data, sent, viol;
    int          fails           = 0;
    int          samples_checked = 0;
    int          cyc             = 0;
    logic [15:0] expq[$];

    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;

    adc_sample_readout_sequencer dut (
        .clk_sys_i                  (clk_sys_i),
        .rst_i                      (rst_i),
        .enable_i                   (enable_i),
        .filter_mode_i              (filter_mode_i),
        .host_flag_output_o         (cmd),
        .filter_bit_clock_output_o  (conv_clk),
        .host_receive_frame_input_i (busy),
        .serial_data_i              (sdata),
        .word_done_o                (word_done),
        .frame_error_o              (frame_error),
        .sample_valid_o             (sample_valid),
        .sample_ready_i             (sample_ready_i),
        .sample_data_o              (sample_data)
    );

    adc_converter_model conv (
        .sample_cmd_i (cmd),
        .conv_clk_i   (conv_clk),
        .word_i       (word),
        .mute_i       (mute),
        .busy_o       (busy),
        .data_o       (sdata),
        .sent_o       (sent),
        .viol_o       (viol)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask : cmp_flag

    task automatic cmp_count(input int got, input int exp);
        cmp_word(got[15:0], exp[15:0]);
    endtask : cmp_count

    function automatic logic probe(input int sel);
        case (sel)
            S_CMD:   return cmd;
            S_CLK:   return conv_clk;
            S_DONE:  return word_done;
            S_ERR:   return frame_error;
            default: return sample_valid;
        endcase
    endfunction : probe

    task automatic wait_for(input int sel, input logic v, input int bound, output bit hit);
        hit = 1'b0;
        for (int i = 0; i < bound && !hit; i++) begin
            @(negedge clk_sys_i);
            hit = (probe(sel) === v);
        end
    endtask : wait_for

    // A wait that runs out of its bound ends the run.
    task automatic need(input int sel, input logic v, input int bound);
        bit hit;
        wait_for(sel, v, bound, hit);
        if (!hit) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, !v, v);
            test_done();
        end
    endtask : need

    task automatic take_word(input logic [15:0] exp);
        need(S_VALID, 1'b1, 3000);
        cmp_word(sample_data, exp);
        sample_ready_i = 1'b1;
        @(negedge clk_sys_i);
        sample_ready_i = 1'b0;
    endtask : take_word

    task automatic do_reset();
        @(negedge clk_sys_i);
        rst_i          = 1'b1;
        enable_i       = 1'b0;
        filter_mode_i  = 1'b0;
        sample_ready_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        do_reset();
        cmp_flag(cmd, 1'b1);
        cmp_flag(conv_clk, 1'b0);
        cmp_flag(sample_valid, 1'b0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_timing();
        int          t0;
        logic [15:0] exp;
        enable_i = 1'b1;
        need(S_CMD, 1'b0, 3000);
        exp = word + sent;
        t0  = cyc;
        need(S_CLK, 1'b1, 200);
        cmp_count(cyc - t0, 63);
        t0 = cyc;
        need(S_CLK, 1'b0, 200);
        cmp_count(cyc - t0, 63);
        need(S_DONE, 1'b1, 2500);
        cmp_flag(cmd, 1'b1);
        cmp_flag(conv_clk, 1'b0);
        t0 = cyc;
        need(S_VALID, 1'b1, 10);
        cmp_count(cyc - t0, 2);
        take_word(exp);
        $display("t_timing done");
    endtask : t_timing

    task automatic t_rate();
        int t0;
        sample_ready_i = 1'b1;
        need(S_CMD, 1'b0, 3000);
        t0 = cyc;
        for (int i = 0; i < 2; i++) begin
            need(S_CMD, 1'b1, 3000);
            need(S_CMD, 1'b0, 3000);
            cmp_flag((cyc - t0) >= 2500, 1'b1);
            t0 = cyc;
        end
        sample_ready_i = 1'b0;
        $display("t_rate done");
    endtask : t_rate

    task automatic t_fill();
        int n;
        bit hit;
        do_reset();
        word     = 16'h7FF8;
        enable_i = 1'b1;
        expq.delete();
        for (n = 0; n < 18; n++) begin
            wait_for(S_CMD, 1'b0, 6000, hit);
            if (!hit) begin
                break;
            end
            expq.push_back(word + sent);
            need(S_CMD, 1'b1, 3000);
        end
        // A full store must hold off the next sample command.
        cmp_count(n, 17);
        foreach (expq[i]) begin
            take_word(expq[i]);
            @(negedge clk_sys_i);
        end
        cmp_flag(sample_valid, 1'b0);
        need(S_CMD, 1'b0, 3000);
        $display("t_fill done");
    endtask : t_fill

    task automatic t_filter();
        int          t0;
        logic [15:0] e[4];
        do_reset();
        filter_mode_i = 1'b1;
        enable_i      = 1'b1;
        for (int i = 0; i < 4; i++) begin
            need(S_CMD, 1'b0, 3000);
            if (i > 0) begin
                cmp_flag((cyc - t0) >= 2605, 1'b1);
            end
            t0   = cyc;
            e[i] = word + sent;
            need(S_DONE, 1'b1, 2500);
        end
        take_word(e[0]);
        take_word(e[2]);
        repeat (4) @(negedge clk_sys_i);
        cmp_flag(sample_valid, 1'b0);
        $display("t_filter done");
    endtask : t_filter

    task automatic t_frame_error();
        logic [15:0] exp;
        do_reset();
        mute     = 1'b1;
        enable_i = 1'b1;
        need(S_CMD, 1'b0, 3000);
        need(S_ERR, 1'b1, 5400);
        need(S_CMD, 1'b1, 4);
        cmp_flag(sample_valid, 1'b0);
        mute = 1'b0;
        need(S_CMD, 1'b0, 3000);
        exp = word + sent;
        take_word(exp);
        $display("t_frame_error done");
    endtask : t_frame_error

    initial begin
        t_reset();
        t_timing();
        t_rate();
        t_fill();
        t_filter();
        t_frame_error();
        cmp_word(viol, 16'h0000);
        test_done();
    end
endmodule : adc_sample_readout_sequencer_test

// File: adc_seq_defines.svh
// Timing and framing constants for the converter readout sequencer.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define CLK_FREQ_KHZ      250000
`define SCLK_FREQ_KHZ     2000
`define SCLK_HALF_CYC     ((`CLK_FREQ_KHZ + 2 * `SCLK_FREQ_KHZ - 1) / (2 * `SCLK_FREQ_KHZ))
`define MAX_RATE_KHZ      100
`define MIN_PERIOD_CYC    ((`CLK_FREQ_KHZ + `MAX_RATE_KHZ - 1) / `MAX_RATE_KHZ)
`define FILTER_RATE_KHZ   96
`define FILTER_PERIOD_CYC ((`CLK_FREQ_KHZ + `FILTER_RATE_KHZ - 1) / `FILTER_RATE_KHZ)
`define ACQ_TIME_NS       500
`define ACQ_CYC           ((`ACQ_TIME_NS * `CLK_FREQ_KHZ + 999999) / 1000000)
`define WORD_BITS         16
`define CONV_TIMEOUT_CLKS 40
`define FIFO_DEPTH        16

`endif

// File: adc_seq_pkg.sv
// Types shared by the converter readout sequencer.
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQUIRE,
        ST_CONVERT
    } seq_state_t;

endpackage : adc_seq_pkg

// File: sample_fifo.sv
// Sample word FIFO with registered read data and valid/ready on both sides.
`timescale 1ns/1ps

module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_i,   // System clock.
    input  wire logic             rst_i,       // Synchronous reset, active high.
    input  wire logic             in_valid_i,  // Write word offered.
    output logic                  in_ready_o,  // Space in the store.
    input  wire logic [WIDTH-1:0] in_data_i,   // Write word.
    output logic                  out_valid_o, // Read word present.
    input  wire logic             out_ready_i, // Reader takes the word.
    output logic      [WIDTH-1:0] out_data_o   // Read word, registered.
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             wr;
    logic             rd;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign wr         = in_valid_i && in_ready_o;
    assign rd         = (count != '0) && (!out_valid_o || out_ready_i);

    always_comb begin
        next_wr_ptr    = wr ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr    = rd ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count     = count + (AW+1)'(wr) - (AW+1)'(rd);
        next_out_valid = out_valid_o;
        next_out_data  = out_data_o;
        if (rd) begin
            next_out_valid = 1'b1;
            next_out_data  = mem[rd_ptr];
        end else if (out_ready_i) begin
            next_out_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else begin
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            out_valid_o <= next_out_valid;
            out_data_o  <= next_out_data;
        end
        if (wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule : sample_fifo
